//--- design/csf_pkg.sv
// Package with the map, fields and constants of the chip settings block
`default_nettype none
package csf_pkg;
   // APB register byte offsets
   localparam logic [11:0] CSF_OFF_INTCFG = 12'h000;
   localparam logic [11:0] CSF_OFF_VID = 12'h004;
   localparam logic [11:0] CSF_OFF_PID = 12'h008;
   localparam logic [11:0] CSF_OFF_PWRATTR = 12'h00C;
   localparam logic [11:0] CSF_OFF_CURRENT = 12'h010;
   localparam logic [11:0] CSF_OFF_PASSWD = 12'h014;
   localparam logic [11:0] CSF_OFF_RESPIDX = 12'h018;
   localparam logic [11:0] CSF_OFF_RESPDATA = 12'h01C;
   localparam logic [11:0] CSF_OFF_STATUS = 12'h020;
   localparam logic [11:0] CSF_OFF_MASK = 12'h024;
   localparam logic [11:0] CSF_OFF_LIVE = 12'h028;

   // Interrupt configuration byte fields
   localparam int CSF_BIT_NEGEDGE = 6;
   localparam int CSF_BIT_POSEDGE = 5;
   localparam int CSF_LVL_HI = 4;
   localparam int CSF_LVL_LO = 3;
   localparam int CSF_BIT_REFSRC = 2;
   localparam logic [7:0] CSF_INTCFG_WMASK = 8'h7C;

   // Status and mask bits
   localparam int CSF_ST_EDGE = 0;
   localparam int CSF_ST_W = 1;

   // Response byte indices
   localparam logic [4:0] CSF_IDX_INTCFG = 5'h07;
   localparam logic [4:0] CSF_IDX_VID_LO = 5'h08;
   localparam logic [4:0] CSF_IDX_VID_HI = 5'h09;
   localparam logic [4:0] CSF_IDX_PID_LO = 5'h0A;
   localparam logic [4:0] CSF_IDX_PID_HI = 5'h0B;
   localparam logic [4:0] CSF_IDX_PWRATTR = 5'h0C;
   localparam logic [4:0] CSF_IDX_CURRENT = 5'h0D;
   localparam logic [4:0] CSF_IDX_PW1 = 5'h0E;
   localparam logic [4:0] CSF_IDX_PW2 = 5'h0F;
   localparam logic [4:0] CSF_IDX_PW3 = 5'h10;

   // Reset values
   localparam logic [7:0] CSF_RST_INTCFG = 8'h00;
   localparam logic [15:0] CSF_RST_VID = 16'h0000; // Arbitrary value
   localparam logic [15:0] CSF_RST_PID = 16'h0000; // Arbitrary value
   localparam logic [7:0] CSF_RST_PWRATTR = 8'h80;
   localparam logic [7:0] CSF_RST_CURRENT = 8'h32;
   localparam logic [23:0] CSF_RST_PASSWD = 24'h000000;
   localparam logic [4:0] CSF_RST_RESPIDX = 5'h00;
   localparam logic [CSF_ST_W-1:0] CSF_RST_MASK = 1'h0;

   // ADC reference level codes and millivolt values
   typedef enum logic [1:0] {
      CSF_VREF_OFF = 2'b00,
      CSF_VREF_1024 = 2'b01,
      CSF_VREF_2048 = 2'b10,
      CSF_VREF_4096 = 2'b11
   } csf_vref_t;
   localparam logic [12:0] CSF_MV_1024 = 13'h0400;
   localparam logic [12:0] CSF_MV_2048 = 13'h0800;
   localparam logic [12:0] CSF_MV_4096 = 13'h1000;
endpackage : csf_pkg
`default_nettype wire

//--- design/csf_edge_det.sv
// Synchroniser and edge detector for the external interrupt pin
`default_nettype none
module csf_edge_det
   import csf_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pin and events
   input wire logic pin_async,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_ff;
   logic sync_ff;
   logic prev_ff;

   // First stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         meta_ff <= pin_async;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign level = sync_ff;
   assign rise = sync_ff & ~prev_ff;
   assign fall = ~sync_ff & prev_ff;
endmodule : csf_edge_det
`default_nettype wire

//--- design/csf_settings.sv
// Chip settings response fields with APB access and edge interrupt
//
// Contract
// RULE1 - Positive-edge enable sets flag on rising edge
// RULE2 - Negative-edge enable sets flag on falling edge
// RULE3 - Decode two-bit ADC reference level field
// RULE4 - Reference-source bit picks internal reference or supply
// RULE5 - Vendor id low at 8, high at 9
// RULE6 - Product id low at 10, high at 11
// RULE7 - Power attributes at 12, used in descriptor
// RULE8 - Current stored halved at 13, requested doubled
// RULE9 - Password bytes one to three at 14-16
// RULE10 - Don't-care bits read zero, ignored on write
//
// The implementer's own choices: the APB register port and the register offsets.
`default_nettype none
module csf_settings
   import csf_pkg::*;
(
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External interrupt pin
   input wire logic int_pin,
   // Interrupt to the system
   output logic irq,
   // ADC reference control
   output logic adc_vref_on,
   output logic [12:0] adc_vref_mv,
   output logic adc_ref_internal,
   // Enumeration settings
   output logic [15:0] usb_vid,
   output logic [15:0] usb_pid,
   output logic [7:0] usb_power_attr,
   output logic [8:0] usb_max_power_ma
);
   // Stored settings
   logic [7:0] intcfg_ff;
   logic [15:0] vid_ff;
   logic [15:0] pid_ff;
   logic [7:0] pwrattr_ff;
   logic [7:0] current_ff;
   logic [23:0] passwd_ff;
   logic [4:0] respidx_ff;
   logic [CSF_ST_W-1:0] status_ff;
   logic [CSF_ST_W-1:0] mask_ff;
   logic [31:0] rdata_ff;
   logic [12:0] mv_ff;
   logic vref_on_ff;
   logic ref_int_ff;

   logic [7:0] nxt_intcfg;
   logic [CSF_ST_W-1:0] nxt_status;
   logic [12:0] nxt_mv;
   logic [31:0] nxt_rdata;

   // Edge events from the pin
   logic pin_level;
   logic pin_rise;
   logic pin_fall;

   csf_edge_det csf_edge_det_inst (
      .pclk(pclk),
      .presetn(presetn),
      .pin_async(int_pin),
      .level(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // APB decode; slave never waits
   wire access = psel & penable;
   wire wr_en = access & pwrite;
   wire rd_en = access & ~pwrite;
   wire hit_intcfg = (paddr == CSF_OFF_INTCFG);
   wire hit_vid = (paddr == CSF_OFF_VID);
   wire hit_pid = (paddr == CSF_OFF_PID);
   wire hit_pwrattr = (paddr == CSF_OFF_PWRATTR);
   wire hit_current = (paddr == CSF_OFF_CURRENT);
   wire hit_passwd = (paddr == CSF_OFF_PASSWD);
   wire hit_respidx = (paddr == CSF_OFF_RESPIDX);
   wire hit_respdata = (paddr == CSF_OFF_RESPDATA);
   wire hit_status = (paddr == CSF_OFF_STATUS);
   wire hit_mask = (paddr == CSF_OFF_MASK);
   wire hit_live = (paddr == CSF_OFF_LIVE);
   wire hit_any = hit_intcfg | hit_vid | hit_pid | hit_pwrattr
      | hit_current | hit_passwd | hit_respidx | hit_respdata
      | hit_status | hit_mask | hit_live;
   // Read-only registers also refuse writes
   wire bad_wr = pwrite & (hit_respdata | hit_live);

   assign pready = 1'b1;
   assign pslverr = access & (~hit_any | bad_wr);

   wire wr_ok = wr_en & hit_any & ~bad_wr;

   // Per-register write strobes, refused writes never reach them
   wire wr_intcfg = wr_ok & hit_intcfg;
   wire wr_vid = wr_ok & hit_vid;
   wire wr_pid = wr_ok & hit_pid;
   wire wr_pwrattr = wr_ok & hit_pwrattr;
   wire wr_current = wr_ok & hit_current;
   wire wr_passwd = wr_ok & hit_passwd;
   wire wr_respidx = wr_ok & hit_respidx;
   wire wr_status = wr_ok & hit_status;
   wire wr_mask = wr_ok & hit_mask;

   // Don't-care bits are masked off on write
   assign nxt_intcfg = pwdata[7:0] & CSF_INTCFG_WMASK; // [RULE10]

   // Edge flag: enabled edges set, a written one clears
   wire edge_evt = (intcfg_ff[CSF_BIT_POSEDGE] & pin_rise) // [RULE1]
      | (intcfg_ff[CSF_BIT_NEGEDGE] & pin_fall); // [RULE2]
   wire [CSF_ST_W-1:0] st_clr = wr_status ?
      pwdata[CSF_ST_W-1:0] : {CSF_ST_W{1'b0}};
   wire [CSF_ST_W-1:0] st_set = {CSF_ST_W{edge_evt}};
   // Set wins over a clear in the same cycle
   assign nxt_status = (status_ff & ~st_clr) | st_set; // [RULE1] [RULE2]

   // ADC reference level decode
   wire [1:0] lvl_code = intcfg_ff[CSF_LVL_HI:CSF_LVL_LO];
   always_comb begin
      unique case (csf_vref_t'(lvl_code))
         CSF_VREF_OFF: nxt_mv = 13'h0000; // [RULE3]
         CSF_VREF_1024: nxt_mv = CSF_MV_1024; // [RULE3]
         CSF_VREF_2048: nxt_mv = CSF_MV_2048; // [RULE3]
         CSF_VREF_4096: nxt_mv = CSF_MV_4096; // [RULE3]
      endcase
   end

   // Response byte selected by the index register
   logic [7:0] resp_byte;
   always_comb begin
      unique case (respidx_ff)
         CSF_IDX_INTCFG: resp_byte = intcfg_ff & CSF_INTCFG_WMASK; // [RULE10]
         CSF_IDX_VID_LO: resp_byte = vid_ff[7:0]; // [RULE5]
         CSF_IDX_VID_HI: resp_byte = vid_ff[15:8]; // [RULE5]
         CSF_IDX_PID_LO: resp_byte = pid_ff[7:0]; // [RULE6]
         CSF_IDX_PID_HI: resp_byte = pid_ff[15:8]; // [RULE6]
         CSF_IDX_PWRATTR: resp_byte = pwrattr_ff; // [RULE7]
         CSF_IDX_CURRENT: resp_byte = current_ff; // [RULE8]
         CSF_IDX_PW1: resp_byte = passwd_ff[7:0]; // [RULE9]
         CSF_IDX_PW2: resp_byte = passwd_ff[15:8]; // [RULE9]
         CSF_IDX_PW3: resp_byte = passwd_ff[23:16]; // [RULE9]
         default: resp_byte = 8'h00;
      endcase
   end

   // Read data, taken at the access edge's start
   wire [31:0] rd_intcfg = {24'h000000, intcfg_ff};
   wire [31:0] rd_vid = {16'h0000, vid_ff};
   wire [31:0] rd_pid = {16'h0000, pid_ff};
   wire [31:0] rd_pwr = {24'h000000, pwrattr_ff};
   wire [31:0] rd_cur = {24'h000000, current_ff};
   wire [31:0] rd_pw = {8'h00, passwd_ff};
   wire [31:0] rd_idx = {27'h0000000, respidx_ff};
   wire [31:0] rd_resp = {24'h000000, resp_byte};
   wire [31:0] rd_st = {{(32 - CSF_ST_W){1'b0}}, status_ff};
   wire [31:0] rd_mask = {{(32 - CSF_ST_W){1'b0}}, mask_ff};
   wire [31:0] rd_live = {31'h00000000, pin_level};

   always_comb begin
      nxt_rdata = 32'h00000000;
      if (hit_intcfg) nxt_rdata = rd_intcfg;
      if (hit_vid) nxt_rdata = rd_vid;
      if (hit_pid) nxt_rdata = rd_pid;
      if (hit_pwrattr) nxt_rdata = rd_pwr;
      if (hit_current) nxt_rdata = rd_cur;
      if (hit_passwd) nxt_rdata = rd_pw;
      if (hit_respidx) nxt_rdata = rd_idx;
      if (hit_respdata) nxt_rdata = rd_resp;
      if (hit_status) nxt_rdata = rd_st;
      if (hit_mask) nxt_rdata = rd_mask;
      if (hit_live) nxt_rdata = rd_live;
   end

   // Registered in the setup cycle so prdata comes from a flop
   wire rd_setup = psel & ~penable & ~pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_ff <= 32'h00000000;
      end else if (rd_setup) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign prdata = rd_en ? rdata_ff : 32'h00000000;

   // Settings registers, one per block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         intcfg_ff <= CSF_RST_INTCFG;
      end else if (wr_intcfg) begin
         intcfg_ff <= nxt_intcfg; // [RULE10]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vid_ff <= CSF_RST_VID;
      end else if (wr_vid) begin
         vid_ff <= pwdata[15:0]; // [RULE5]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pid_ff <= CSF_RST_PID;
      end else if (wr_pid) begin
         pid_ff <= pwdata[15:0]; // [RULE6]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwrattr_ff <= CSF_RST_PWRATTR;
      end else if (wr_pwrattr) begin
         pwrattr_ff <= pwdata[7:0]; // [RULE7]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         current_ff <= CSF_RST_CURRENT;
      end else if (wr_current) begin
         current_ff <= pwdata[7:0]; // [RULE8]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         passwd_ff <= CSF_RST_PASSWD;
      end else if (wr_passwd) begin
         passwd_ff <= pwdata[23:0]; // [RULE9]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         respidx_ff <= CSF_RST_RESPIDX;
      end else if (wr_respidx) begin
         respidx_ff <= pwdata[4:0];
      end
   end

   // Interrupt status and mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_ff <= {CSF_ST_W{1'b0}};
      end else begin
         status_ff <= nxt_status; // [RULE1] [RULE2]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_ff <= CSF_RST_MASK;
      end else if (wr_mask) begin
         mask_ff <= pwdata[CSF_ST_W-1:0];
      end
   end

   assign irq = |(status_ff & mask_ff);

   // Reference outputs registered to keep analog controls glitch free
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mv_ff <= 13'h0000;
      end else begin
         mv_ff <= nxt_mv; // [RULE3]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vref_on_ff <= 1'b0;
      end else begin
         vref_on_ff <= (lvl_code != CSF_VREF_OFF); // [RULE3]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_int_ff <= 1'b0;
      end else begin
         ref_int_ff <= intcfg_ff[CSF_BIT_REFSRC]; // [RULE4]
      end
   end

   // 4.096 V is only useful with enough supply; not checked here
   assign adc_vref_mv = mv_ff;
   assign adc_vref_on = vref_on_ff;
   // One selects internal_voltage_reference, zero the supply rail
   assign adc_ref_internal = ref_int_ff; // [RULE4]

   // Enumeration values straight from the stored settings
   assign usb_vid = vid_ff; // [RULE5]
   assign usb_pid = pid_ff; // [RULE6]
   assign usb_power_attr = pwrattr_ff; // [RULE7]
   // Stored halved so 8 bits reach 510 mA
   assign usb_max_power_ma = {current_ff, 1'b0}; // [RULE8]
endmodule : csf_settings
`default_nettype wire

//--- test/csf_settings_sva.sv
// Port checker for the chip settings block
`default_nettype none
module csf_settings_sva
   import csf_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Settings outputs
   input wire logic adc_vref_on,
   input wire logic [12:0] adc_vref_mv,
   input wire logic adc_ref_internal,
   input wire logic [15:0] usb_vid,
   input wire logic [15:0] usb_pid,
   input wire logic [7:0] usb_power_attr,
   input wire logic [8:0] usb_max_power_ma,
   // Interrupt
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Write access phase to one address
   sequence wr_s(logic [11:0] a);
      psel && penable && pwrite && paddr == a;
   endsequence

   chk_ready_high: assert property (pready)
      else $error("pready low");
   chk_idle_quiet: assert property (
      !(psel && penable) |-> !pslverr && prdata == 32'h0)
      else $error("bus outputs not quiet");
   chk_vref_on: assert property (
      adc_vref_on == (adc_vref_mv != 13'h0000))
      else $error("reference enable wrong");
   chk_vref_set: assert property (
      adc_vref_mv inside {13'h0000, 13'h0400, 13'h0800, 13'h1000})
      else $error("reference level illegal");
   chk_vid_write: assert property (
      wr_s(CSF_OFF_VID) |=> usb_vid == $past(pwdata[15:0]))
      else $error("vendor id not taken");
   chk_pid_write: assert property (
      wr_s(CSF_OFF_PID) |=> usb_pid == $past(pwdata[15:0]))
      else $error("product id not taken");
   chk_attr_write: assert property (
      wr_s(CSF_OFF_PWRATTR) |=> usb_power_attr == $past(pwdata[7:0]))
      else $error("power attributes not taken");
   chk_current_double: assert property (
      wr_s(CSF_OFF_CURRENT) |=>
      usb_max_power_ma == {$past(pwdata[7:0]), 1'b0})
      else $error("current not doubled");
   chk_src_follow: assert property (
      wr_s(CSF_OFF_INTCFG) |-> ##2 adc_ref_internal == $past(pwdata[2], 2))
      else $error("reference source wrong");
   chk_irq_masked: assert property (
      wr_s(CSF_OFF_MASK) ##0 !pwdata[CSF_ST_EDGE] |=> !irq)
      else $error("irq not masked");
   chk_ro_refused: assert property (
      psel && penable && pwrite
      && (paddr == CSF_OFF_RESPDATA || paddr == CSF_OFF_LIVE) |-> pslverr)
      else $error("read-only write not refused");
endmodule : csf_settings_sva
`default_nettype wire

//--- test/csf_pin_src.sv
// Model of the external source driving the interrupt pin
`default_nettype none
module csf_pin_src (
   // Clock
   input wire logic pclk,
   // Level wanted by the bench
   input wire logic want_high,
   // Pin
   output logic int_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Source is slow: pin moves only just after an edge
   initial int_pin = 1'b0;
   always @(posedge pclk) int_pin <= want_high;
endmodule : csf_pin_src
`default_nettype wire

//--- test/csf_settings_tb.sv
// Self-checking bench for the chip settings block
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
   n_errors++; $display("mismatch %s exp %0h got %0h", nm, ex, gt); end end
module csf_settings_tb
   import csf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, want_high, int_pin;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, irq, adc_vref_on, adc_ref_internal, er;
   logic [12:0] adc_vref_mv;
   logic [15:0] usb_vid, usb_pid;
   logic [7:0] usb_power_attr;
   logic [8:0] usb_max_power_ma;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;

   csf_settings csf_settings_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .int_pin(int_pin), .irq(irq),
      .adc_vref_on(adc_vref_on), .adc_vref_mv(adc_vref_mv),
      .adc_ref_internal(adc_ref_internal), .usb_vid(usb_vid),
      .usb_pid(usb_pid), .usb_power_attr(usb_power_attr),
      .usb_max_power_ma(usb_max_power_ma));
   csf_pin_src csf_pin_src_inst (.pclk(pclk), .want_high(want_high),
      .int_pin(int_pin));

   task automatic tally_and_finish();
      if (n_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   task automatic apb_go(input logic [11:0] a, input logic w,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb_go

   task automatic apb_wr(input logic [11:0] a, input logic [31:0] d);
      apb_go(a, 1'b1, d);
   endtask : apb_wr

   task automatic wait_irq(input int n);
      repeat (n) begin
         @(posedge pclk);
         if (irq === 1'b1) break;
      end
   endtask : wait_irq

   task automatic t_resp();
      logic [7:0] eb [9] = '{8'hC4, 8'hB7, 8'h9A, 8'h1E, 8'hA0, 8'h7D,
         8'h91, 8'h3C, 8'h5A};
      `CHK("attr rst", 8'h80, usb_power_attr)
      `CHK("ma rst", 9'h064, usb_max_power_ma)
      apb_wr(CSF_OFF_VID, 32'h0000B7C4);
      apb_wr(CSF_OFF_PID, 32'h00001E9A);
      apb_wr(CSF_OFF_PWRATTR, 32'h000000A0);
      apb_wr(CSF_OFF_CURRENT, 32'h0000007D);
      apb_wr(CSF_OFF_PASSWD, 32'h005A3C91);
      `CHK("ma", 9'h0FA, usb_max_power_ma)
      `CHK("vid", 16'hB7C4, usb_vid)
      `CHK("pid", 16'h1E9A, usb_pid)
      `CHK("attr", 8'hA0, usb_power_attr)
      for (int i = 0; i < 9; i++) begin
         apb_wr(CSF_OFF_RESPIDX, 32'(i + 8));
         apb_go(CSF_OFF_RESPDATA, 1'b0, 32'h0);
         `CHK("resp", {24'h0, eb[i]}, rd)
      end
   endtask : t_resp

   task automatic t_cfg();
      logic [12:0] mv [4] = '{13'h0000, 13'h0400, 13'h0800, 13'h1000};
      logic [7:0] w;
      for (int c = 0; c < 4; c++) begin
         // Don't-care bits 7, 1 and 0 are always set on purpose
         w = 8'h83 | 8'(c * 8) | ((c % 2) ? 8'h04 : 8'h00);
         apb_wr(CSF_OFF_INTCFG, {24'h0, w});
         apb_go(CSF_OFF_INTCFG, 1'b0, 32'h0);
         `CHK("cfg", {24'h0, w & 8'h7C}, rd)
         `CHK("mv", mv[c], adc_vref_mv)
         `CHK("on", c != 0, adc_vref_on)
         `CHK("src", w[2], adc_ref_internal)
      end
      apb_wr(CSF_OFF_RESPIDX, 32'h7);
      apb_go(CSF_OFF_RESPDATA, 1'b0, 32'h0);
      `CHK("resp cfg", 32'h1C, rd)
      apb_go(12'h0FC, 1'b0, 32'h0);
      `CHK("unmapped", 33'h100000000, {er, rd})
      apb_go(CSF_OFF_RESPDATA, 1'b1, 32'h000000FF);
      `CHK("ro write", 1'b1, er)
   endtask : t_cfg

   task automatic t_edges();
      apb_wr(CSF_OFF_MASK, 32'h1);
      apb_wr(CSF_OFF_INTCFG, 32'h20);
      want_high <= 1'b1;
      wait_irq(10);
      `CHK("irq rise", 1'b1, irq)
      apb_wr(CSF_OFF_STATUS, 32'h1);
      want_high <= 1'b0;
      wait_irq(10);
      `CHK("irq fall off", 1'b0, irq)
      apb_wr(CSF_OFF_INTCFG, 32'h40);
      want_high <= 1'b1;
      wait_irq(10);
      `CHK("irq rise off", 1'b0, irq)
      apb_go(CSF_OFF_LIVE, 1'b0, 32'h0);
      `CHK("live", 32'h1, rd)
      want_high <= 1'b0;
      wait_irq(10);
      `CHK("irq fall", 1'b1, irq)
      apb_wr(CSF_OFF_MASK, 32'h0);
      @(posedge pclk);
      `CHK("irq masked", 1'b0, irq)
      apb_go(CSF_OFF_STATUS, 1'b0, 32'h0);
      `CHK("status", 32'h1, rd)
   endtask : t_edges

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // Hang guard, far above the fewer than 200 cycles needed
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      want_high = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_resp();
      t_cfg();
      t_edges();
      tally_and_finish();
   end
endmodule : csf_settings_tb

bind csf_settings csf_settings_sva csf_settings_sva_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .adc_vref_on(adc_vref_on),
   .adc_vref_mv(adc_vref_mv), .adc_ref_internal(adc_ref_internal),
   .usb_vid(usb_vid), .usb_pid(usb_pid), .usb_power_attr(usb_power_attr),
   .usb_max_power_ma(usb_max_power_ma), .irq(irq));
`default_nettype wire
